//--- rtl/cpc_pkg.sv
/*
 * shared constants and control bundle for codec power and port clocks.
 * assumes one 50 mhz pclk; master clock is a level made by the host.
 */
package cpc_pkg;
    // control bits the host drives to the codec
    typedef struct packed {
        logic baseband_ref_hold;
        logic baseband_ref_buffer_enable;
        logic baseband_ref_standby;
        logic ref_output_disable;
        logic tx_dac_enable;
        logic rx_adc_enable;
        logic aux_adc_enable;
        logic ramp_dac_enable;
        logic gain_dac_enable;
        logic freq_dac_enable;
        logic freq_dac_low_power;
        logic voice_power_up;
        logic voice_port_disable;
        logic voice_clock_disable;
        logic output_amp_down;
        logic voice_ref_hold;
        logic voice_ref_buffer_enable;
        logic digital_audio_interface_mode;
    } cpc_ctrl_s;

    localparam int CTRL_W = 18;
    localparam int BB_DIV_W = 10;
    localparam int V_DIV_W = 5;
    localparam int V_CNT_W = 7;
    localparam logic [V_DIV_W-1:0] V_DIV_MAX_NORMAL = 5'h10;
    localparam logic [V_DIV_W-1:0] V_DIV_DAI = 5'h18;
    localparam logic [2:0] V_PER_MUL = 3'h5;
    localparam logic [2:0] V_HIGH_MUL = 3'h2;

    // host register map, byte addresses
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] DIV_OFS = 12'h004;
    localparam logic [11:0] CLK_OFS = 12'h008;
    localparam logic [11:0] STAT_OFS = 12'h00c;
    localparam int DIV_BB_LSB = 0;
    localparam int DIV_V_LSB = 16;
    localparam int CLK_MCLK_RUN = 0;
    localparam int CLK_AUX_RUN = 1;
    localparam logic [CTRL_W-1:0] CTRL_RST = 18'h00000;
    localparam logic [BB_DIV_W-1:0] BB_DIV_RST = 10'h000;
    localparam logic [V_DIV_W-1:0] V_DIV_RST = 5'h00;

    // timing
    localparam int PCLK_NS = 20;
    localparam int MCLK_STOP_NS = 200;
    localparam int MCLK_STOP_CYC = (MCLK_STOP_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int PCLK_HZ = 50000000;
    localparam int AUX_MAX_HZ = 6500000;
    localparam int AUX_HALF_MIN = (PCLK_HZ + 2 * AUX_MAX_HZ - 1)
                                  / (2 * AUX_MAX_HZ);
    localparam int MCLK_HALF = 2;
    localparam int SETTLE_NS = 10000;
    localparam int SETTLE_CYC = (SETTLE_NS + PCLK_NS - 1) / PCLK_NS;
    localparam int WARM_NS = 1000;
    localparam int WARM_CYC = (WARM_NS + PCLK_NS - 1) / PCLK_NS;
endpackage : cpc_pkg

//--- rtl/cpc_link_if.sv
/*
 * link between the host processor end and the codec end.
 * assumes both ends share pclk.
 */
`timescale 1ns/1ps
interface cpc_link_if;
    logic master_clock;
    logic aux_port_clock;
    cpc_pkg::cpc_ctrl_s ctrl;
    logic [cpc_pkg::BB_DIV_W-1:0] baseband_clock_divisor;
    logic [cpc_pkg::V_DIV_W-1:0] voice_clock_divisor;
    logic baseband_port_clock;
    logic voice_port_clock;
    logic voice_data_out;
    logic voice_data_out_oe;

    modport device (
        input master_clock, aux_port_clock, ctrl,
        input baseband_clock_divisor, voice_clock_divisor,
        output baseband_port_clock, voice_port_clock,
        output voice_data_out, voice_data_out_oe
    );
    modport host (
        output master_clock, aux_port_clock, ctrl,
        output baseband_clock_divisor, voice_clock_divisor,
        input baseband_port_clock, voice_port_clock,
        input voice_data_out, voice_data_out_oe
    );
endinterface : cpc_link_if

//--- rtl/cpc_device.sv
/*
 * codec end: power state of references and converters, and the
 * baseband and voice port clock dividers run from the master clock.
 * assumes link inputs are synchronous to pclk and the master clock
 * level changes at most every other pclk cycle.
 */
// The address map and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cpc_device #(
    parameter int STOP_CYC = cpc_pkg::MCLK_STOP_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link to host
    cpc_link_if.device link,
    // voice data to send
    input wire logic voice_tx_bit,
    // power state seen by the analog blocks, plus aux clock sample and divisor flag
    output logic mclk_running,
    output logic [5:0] converter_active,
    output logic bb_ref_on,
    output logic bb_ref_low_current,
    output logic bb_ref_out_on,
    output logic voice_codec_on,
    output logic voice_ref_on,
    output logic voice_ref_out_on,
    output logic voice_internal_clk_on,
    output logic voice_amp_on,
    output logic voice_port_active,
    output logic aux_port_clock_seen,
    output logic voice_divisor_bad
);
    localparam int SW = $clog2(STOP_CYC + 1);
    localparam logic [SW-1:0] STOP_LAST = SW'(STOP_CYC);

    cpc_pkg::cpc_ctrl_s c;
    logic mclk_prev;
    logic mclk_rise;
    logic [SW-1:0] idle_cnt;
    logic [5:0] en_vec;
    logic ref_full;
    logic ref_low;
    logic [cpc_pkg::BB_DIV_W-1:0] bb_div;
    logic [cpc_pkg::BB_DIV_W-1:0] bb_cnt;
    logic bb_clk;
    logic [cpc_pkg::V_DIV_W-1:0] v_div;
    logic [cpc_pkg::V_CNT_W-1:0] v_cnt;
    logic [cpc_pkg::V_CNT_W-1:0] v_per;
    logic [cpc_pkg::V_CNT_W-1:0] v_high;
    logic v_clk;
    logic v_stop;
    logic vdo;
    logic vdo_oe;

    assign c = link.ctrl;
    assign mclk_rise = link.master_clock & ~mclk_prev;
    // converter order: tx, rx, aux adc, ramp, gain, freq
    assign en_vec = {c.freq_dac_enable, c.gain_dac_enable,
                     c.ramp_dac_enable, c.aux_adc_enable,
                     c.rx_adc_enable, c.tx_dac_enable};
    // full reference for any converter but freq dac in standby
    assign ref_full = (|en_vec[4:0]) | c.baseband_ref_hold
                      | (c.freq_dac_enable & ~c.baseband_ref_standby);
    assign ref_low = c.freq_dac_enable & c.baseband_ref_standby
                     & ~ref_full;
    // period and high time in master periods, widened first
    assign v_per = cpc_pkg::V_CNT_W'(cpc_pkg::V_PER_MUL)
                   * (cpc_pkg::V_CNT_W'(v_div) + 7'h01);
    assign v_high = cpc_pkg::V_CNT_W'(cpc_pkg::V_HIGH_MUL)
                    * (cpc_pkg::V_CNT_W'(v_div) + 7'h01);
    assign v_stop = c.voice_clock_disable | ~c.voice_power_up;

    // master clock edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk_prev <= 1'b0;
        end else begin
            mclk_prev <= link.master_clock;
        end
    end

    // stop detector: no master edge for the window means stopped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idle_cnt <= STOP_LAST;
            mclk_running <= 1'b0;
        end else if (mclk_rise) begin
            idle_cnt <= '0;
            mclk_running <= 1'b1;
        end else if (idle_cnt != STOP_LAST) begin
            idle_cnt <= idle_cnt + 1'b1;
        end else begin
            mclk_running <= 1'b0;
        end
    end

    // converter power: each enable gates only its own converter
    generate
        for (genvar i = 0; i < 6; i++) begin : g_conv
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    converter_active[i] <= 1'b0;
                end else begin
                    converter_active[i] <= en_vec[i]
                                           & mclk_running;
                end
            end
        end
    endgenerate

    // baseband reference and its output buffer, no voice terms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bb_ref_on <= 1'b0;
            bb_ref_low_current <= 1'b0;
            bb_ref_out_on <= 1'b0;
        end else begin
            bb_ref_on <= ref_full | ref_low;
            bb_ref_low_current <= ref_low;
            // tx dacs need the bias, so tx overrides the buffer bit unless ref_output_disable is set
            bb_ref_out_on <= ref_full
                & (c.baseband_ref_buffer_enable
                   | (c.tx_dac_enable & ~c.ref_output_disable));
        end
    end

    // voice section power, no baseband terms
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voice_codec_on <= 1'b0;
            voice_ref_on <= 1'b0;
            voice_ref_out_on <= 1'b0;
            voice_internal_clk_on <= 1'b0;
            voice_amp_on <= 1'b0;
            voice_port_active <= 1'b0;
        end else begin
            voice_codec_on <= c.voice_power_up;
            voice_internal_clk_on <= c.voice_power_up;
            voice_ref_on <= c.voice_power_up | c.voice_ref_hold;
            voice_ref_out_on <= (c.voice_power_up | c.voice_ref_hold)
                                & c.voice_ref_buffer_enable;
            voice_amp_on <= c.voice_power_up
                            & ~c.output_amp_down;
            voice_port_active <= c.voice_power_up
                                 & ~c.voice_port_disable;
        end
    end

    // voice data pin released while the port is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vdo <= 1'b0;
            vdo_oe <= 1'b0;
        end else begin
            vdo_oe <= c.voice_power_up & ~c.voice_port_disable;
            vdo <= voice_tx_bit;
        end
    end

    // aux port clock is only observed, never generated here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_port_clock_seen <= 1'b0;
        end else begin
            aux_port_clock_seen <= link.aux_port_clock;
        end
    end

    // baseband divider; a nonzero divisor only reloads at terminal count so a
    // change mid-period to a nonzero divisor cannot give a runt pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bb_div <= cpc_pkg::BB_DIV_RST;
            bb_cnt <= '0;
            bb_clk <= 1'b0;
        end else if (bb_div == '0) begin
            // zero passes the master clock through
            bb_clk <= link.master_clock;
            if (mclk_rise) begin
                bb_div <= link.baseband_clock_divisor;
                bb_cnt <= '0;
            end
        end else if (mclk_rise) begin
            // no edge, no count: a stopped master freezes the phase
            if (bb_cnt >= bb_div - 1'b1) begin
                bb_cnt <= '0;
                bb_clk <= ~bb_clk;
                bb_div <= link.baseband_clock_divisor;
            end else begin
                bb_cnt <= bb_cnt + 1'b1;
            end
        end
    end

    // voice divider: high for two fifths, low for three fifths
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            v_div <= cpc_pkg::V_DIV_RST;
            v_cnt <= '0;
            v_clk <= 1'b0;
        end else if (v_stop) begin
            v_cnt <= '0;
            v_clk <= 1'b0;
            v_div <= link.voice_clock_divisor;
        end else if (mclk_rise) begin
            if (v_cnt >= v_per - 1'b1) begin
                v_cnt <= '0;
                v_div <= link.voice_clock_divisor;
                v_clk <= 1'b1;
            end else begin
                v_cnt <= v_cnt + 1'b1;
                v_clk <= (v_cnt + 1'b1) < v_high;
            end
        end
    end

    // flags a divisor outside the range allowed for the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            voice_divisor_bad <= 1'b0;
        end else if (c.digital_audio_interface_mode) begin
            voice_divisor_bad <= link.voice_clock_divisor
                                 != cpc_pkg::V_DIV_DAI;
        end else begin
            voice_divisor_bad <= link.voice_clock_divisor
                                 > cpc_pkg::V_DIV_MAX_NORMAL;
        end
    end

    // link outputs straight from flip-flops
    assign link.baseband_port_clock = bb_clk;
    assign link.voice_port_clock = v_clk;
    assign link.voice_data_out = vdo;
    assign link.voice_data_out_oe = vdo_oe;
endmodule : cpc_device

//--- rtl/cpc_host.sv
/*
 * host end: apb register file holding codec control bits, master
 * and aux clock generation, safe clock stop and settle tracking.
 * assumes an apb master on pclk and the codec end on the link.
 */
`timescale 1ns/1ps
module cpc_host #(
    parameter int MCLK_HALF = cpc_pkg::MCLK_HALF,
    parameter int AUX_HALF = cpc_pkg::AUX_HALF_MIN,
    parameter int SETTLE_CYC = cpc_pkg::SETTLE_CYC,
    parameter int WARM_CYC = cpc_pkg::WARM_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // link to codec
    cpc_link_if.host link
);
    typedef enum logic [1:0] {
        CPC_STOPPED = 2'b00,
        CPC_WARM = 2'b01,
        CPC_RUN = 2'b10,
        CPC_PARK = 2'b11
    } cpc_mst_e;

    cpc_mst_e st;
    logic [cpc_pkg::CTRL_W-1:0] ctrl_reg;
    logic [cpc_pkg::BB_DIV_W-1:0] bb_div_reg;
    logic [cpc_pkg::V_DIV_W-1:0] v_div_reg;
    logic mclk_run;
    logic aux_run;
    logic hw_lp;
    logic mclk_on;
    logic mclk;
    logic aux_clk;
    logic [15:0] mclk_cnt;
    logic [15:0] aux_cnt;
    logic [15:0] warm_cnt;
    logic [19:0] settle_cnt;
    logic [6:0] pwr_prev;
    logic [6:0] pwr_now;
    logic access;
    logic hit;
    logic [31:0] rd;
    cpc_pkg::cpc_ctrl_s c;

    assign c = ctrl_reg;
    assign access = psel & penable & ~pready;
    assign pwr_now = {c.voice_power_up, c.tx_dac_enable,
                      c.rx_adc_enable, c.aux_adc_enable,
                      c.ramp_dac_enable, c.gain_dac_enable,
                      c.freq_dac_enable};

    // read mux and address decode
    always_comb begin
        hit = 1'b1;
        rd = 32'h0000_0000;
        case (paddr)
            cpc_pkg::CTRL_OFS: rd[cpc_pkg::CTRL_W-1:0] = ctrl_reg;
            cpc_pkg::DIV_OFS: begin
                rd[cpc_pkg::DIV_BB_LSB +: cpc_pkg::BB_DIV_W] = bb_div_reg;
                rd[cpc_pkg::DIV_V_LSB +: cpc_pkg::V_DIV_W] = v_div_reg;
            end
            cpc_pkg::CLK_OFS: begin
                rd[cpc_pkg::CLK_MCLK_RUN] = mclk_run;
                rd[cpc_pkg::CLK_AUX_RUN] = aux_run;
            end
            cpc_pkg::STAT_OFS: rd[5:0] = {link.voice_data_out_oe,
                link.voice_port_clock, link.baseband_port_clock,
                settle_cnt == '0, hw_lp, mclk_on};
            default: hit = 1'b0;
        endcase
    end

    // apb: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= access;
            pslverr <= access & ~hit;
            if (access && !pwrite) begin
                prdata <= rd;
            end
        end
    end

    // register writes; an unmapped write is ignored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= cpc_pkg::CTRL_RST;
            bb_div_reg <= cpc_pkg::BB_DIV_RST;
            v_div_reg <= cpc_pkg::V_DIV_RST;
            mclk_run <= 1'b0;
            aux_run <= 1'b0;
        end else if (access && pwrite) begin
            case (paddr)
                cpc_pkg::CTRL_OFS: ctrl_reg <= pwdata[cpc_pkg::CTRL_W-1:0];
                cpc_pkg::DIV_OFS: begin
                    bb_div_reg <=
                        pwdata[cpc_pkg::DIV_BB_LSB +: cpc_pkg::BB_DIV_W];
                    v_div_reg <=
                        pwdata[cpc_pkg::DIV_V_LSB +: cpc_pkg::V_DIV_W];
                end
                cpc_pkg::CLK_OFS: begin
                    mclk_run <= pwdata[cpc_pkg::CLK_MCLK_RUN];
                    aux_run <= pwdata[cpc_pkg::CLK_AUX_RUN];
                end
                default: mclk_run <= mclk_run;
            endcase
        end
    end

    // master clock sequencer: low power goes up before the stop and
    // drops only after a warm-up once the clock runs again
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= CPC_STOPPED;
            hw_lp <= 1'b1;
            mclk_on <= 1'b0;
            warm_cnt <= '0;
        end else begin
            case (st)
                CPC_STOPPED: if (mclk_run) begin
                    mclk_on <= 1'b1;
                    warm_cnt <= 16'(WARM_CYC);
                    st <= CPC_WARM;
                end
                CPC_WARM: if (warm_cnt == '0) begin
                    hw_lp <= 1'b0;
                    st <= CPC_RUN;
                end else begin
                    warm_cnt <= warm_cnt - 1'b1;
                end
                CPC_RUN: if (!mclk_run) begin
                    hw_lp <= 1'b1;
                    st <= CPC_PARK;
                end
                CPC_PARK: if (!mclk) begin
                    mclk_on <= 1'b0;
                    st <= CPC_STOPPED;
                end
                default: st <= CPC_STOPPED;
            endcase
        end
    end

    // master clock divider, holds its level when off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mclk <= 1'b0;
            mclk_cnt <= '0;
        end else if (mclk_on) begin
            if (mclk_cnt >= 16'(MCLK_HALF - 1)) begin
                mclk_cnt <= '0;
                mclk <= ~mclk;
            end else begin
                mclk_cnt <= mclk_cnt + 1'b1;
            end
        end
    end

    // aux clock; half period never below the 6.5 mhz limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            aux_clk <= 1'b0;
            aux_cnt <= '0;
        end else if (aux_run) begin
            if (aux_cnt >= 16'(AUX_HALF - 1)) begin
                aux_cnt <= '0;
                aux_clk <= ~aux_clk;
            end else begin
                aux_cnt <= aux_cnt + 1'b1;
            end
        end
    end

    // settle timer restarts when the voice section or any converter powers up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_prev <= '0;
            settle_cnt <= '0;
        end else begin
            pwr_prev <= pwr_now;
            if (|(pwr_now & ~pwr_prev)) begin
                settle_cnt <= 20'(SETTLE_CYC);
            end else if (settle_cnt != '0) begin
                settle_cnt <= settle_cnt - 1'b1;
            end
        end
    end

    // link outputs from registers; low power is software or sequencer
    always_comb begin
        link.ctrl = ctrl_reg;
        link.ctrl.freq_dac_low_power = c.freq_dac_low_power | hw_lp;
    end
    assign link.master_clock = mclk;
    assign link.aux_port_clock = aux_clk;
    assign link.baseband_clock_divisor = bb_div_reg;
    assign link.voice_clock_divisor = v_div_reg;
endmodule : cpc_host

//--- dv/cpc_link_props.sv
/*
 * checks on the host to codec link.
 * assumes default half periods: master 2 and aux 4 pclk cycles.
 */
`timescale 1ns/1ps
module cpc_link_props (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // link signals
    input wire logic master_clock,
    input wire logic aux_port_clock,
    input wire cpc_pkg::cpc_ctrl_s ctrl,
    input wire logic [cpc_pkg::BB_DIV_W-1:0] baseband_clock_divisor,
    input wire logic [cpc_pkg::V_DIV_W-1:0] voice_clock_divisor,
    input wire logic baseband_port_clock,
    input wire logic voice_port_clock,
    input wire logic voice_data_out,
    input wire logic voice_data_out_oe
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // gating
    chk_port_tristate: assert property (ctrl.voice_port_disable |=> !voice_data_out_oe) else $error("data driven");
    chk_vclk_off: assert property ((ctrl.voice_clock_disable || !ctrl.voice_power_up) |=> !voice_port_clock) else $error("vclk on");
    // frozen master and zero divisor bypass
    chk_bb_freeze: assert property ($stable(master_clock)[*5] |-> $stable(baseband_port_clock)) else $error("bclk moved");
    chk_vclk_freeze: assert property ($stable(master_clock)[*5] ##0 (ctrl.voice_power_up && !ctrl.voice_clock_disable && $stable(ctrl)) |-> $stable(voice_port_clock)) else $error("vclk moved");
    chk_bb_bypass: assert property ((baseband_clock_divisor == 10'h000)[*3] |-> baseband_port_clock == $past(master_clock)) else $error("no bypass");
    // host clock shapes and low power while the master is stopped
    chk_mclk_high: assert property ($rose(master_clock) |=> master_clock ##1 !master_clock) else $error("mclk high");
    chk_mclk_low: assert property ($fell(master_clock) |=> !master_clock) else $error("mclk low");
    chk_aux_width: assert property ($changed(aux_port_clock) |=> $stable(aux_port_clock)[*3]) else $error("aux fast");
    chk_lp_stop: assert property ($stable(master_clock)[*8] |-> ctrl.freq_dac_low_power) else $error("no low power");

    // main scenarios reached
    cover property ($rose(baseband_port_clock));
    cover property ($rose(voice_port_clock) && voice_clock_divisor == 5'h18);
    cover property (ctrl.voice_port_disable ##1 !voice_data_out_oe);
endmodule : cpc_link_props

//--- dv/tb_codec_power_and_port_clock_control.sv
/*
 * host and codec ends joined by one link, self-checking.
 * assumes one pclk and the default master half period.
 */
`timescale 1ns/1ps
module tb_codec_power_and_port_clock_control;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [11:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic voice_tx_bit = 1'b0;
    logic [31:0] seed = 32'h0000bd32;
    logic [64:0] notes[$];
    wire [31:0] prdata;
    wire pready, pslverr, mclk_running;
    wire [14:0] pwr;
    int bbt[3] = '{0, 1, 1023};
    int vt[3] = '{0, 16, 24};
    int n_errors = 0;
    int tests_run = 0;
    localparam int MP = 2 * cpc_pkg::MCLK_HALF;

    cpc_link_if cpc_link_if_inst ();
    cpc_host #(.WARM_CYC(3), .SETTLE_CYC(5)) cpc_host_inst (
        .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .link(cpc_link_if_inst.host));
    cpc_device cpc_device_inst (
        .pclk(pclk), .presetn(presetn), .link(cpc_link_if_inst.device),
        .voice_tx_bit(voice_tx_bit), .mclk_running(mclk_running),
        .converter_active(pwr[14:9]), .bb_ref_on(pwr[0]),
        .bb_ref_low_current(pwr[1]), .bb_ref_out_on(pwr[2]),
        .voice_codec_on(pwr[3]), .voice_ref_on(pwr[4]),
        .voice_ref_out_on(pwr[5]), .voice_internal_clk_on(pwr[6]),
        .voice_amp_on(pwr[7]), .voice_port_active(pwr[8]),
        .aux_port_clock_seen(), .voice_divisor_bad());
    cpc_link_props cpc_link_props_inst (
        .pclk, .presetn,
        .master_clock(cpc_link_if_inst.master_clock),
        .aux_port_clock(cpc_link_if_inst.aux_port_clock),
        .ctrl(cpc_link_if_inst.ctrl),
        .baseband_clock_divisor(cpc_link_if_inst.baseband_clock_divisor),
        .voice_clock_divisor(cpc_link_if_inst.voice_clock_divisor),
        .baseband_port_clock(cpc_link_if_inst.baseband_port_clock),
        .voice_port_clock(cpc_link_if_inst.voice_port_clock),
        .voice_data_out(cpc_link_if_inst.voice_data_out),
        .voice_data_out_oe(cpc_link_if_inst.voice_data_out_oe));
    wire [1:0] pclks = {cpc_link_if_inst.baseband_port_clock,
        cpc_link_if_inst.voice_port_clock};

    // free-running 50 mhz clock
    initial forever #10 pclk = ~pclk;

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop

    task automatic cmp(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", what, e, g);
        end
    endtask : cmp

    task automatic cmp_cnt(input string what, input int e, input int g);
        tests_run++;
        if (g != e) begin
            n_errors++;
            $display("FAIL %s expected %0d seen %0d", what, e, g);
        end
    endtask : cmp_cnt

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    // power outputs from ctrl bits, clock running
    function automatic logic [14:0] exp_pwr(input logic [17:0] c);
        logic bref, full;
        full = (|c[13:9]) | c[17] | c[8] & !c[15];
        bref = full | c[8];
        return {c[8], c[9], c[10], c[11], c[12], c[13], c[6] & !c[5],
                c[6] & !c[3], c[6], (c[6] | c[2]) & c[1], c[6] | c[2],
                c[6], full & (c[16] | c[13] & !c[14]),
                c[15] & c[8] & !c[17] & !(|c[13:9]), bref};
    endfunction : exp_pwr

    // one apb transfer; watcher judges the answer
    task automatic xfer(input logic wr, input logic [11:0] a,
                        input logic [31:0] d, input logic [31:0] m,
                        input logic [31:0] e, input logic err);
        int n = 0;
        notes.push_back({err, m, e});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20) begin
            n_errors++;
            report_and_stop();
        end
    endtask : xfer

    // port clock high time and period
    task automatic meas(input bit vc, output int hi, output int per);
        logic p, s;
        hi = 0;
        per = 0;
        s = 1'b1;
        do begin
            p = s;
            @(posedge pclk);
            s = vc ? pclks[0] : pclks[1];
            per++;
            hi += p;
        end while (!(s && !p) && per < 9000);
    endtask : meas

    // bus answers against oldest note
    always @(posedge pclk) begin
        logic [64:0] nt;
        if (psel && penable && pready === 1'b1 && notes.size() > 0) begin
            nt = notes.pop_front();
            cmp("prdata", nt[31:0], prdata & nt[63:32]);
            cmp("pslverr", {31'h0, nt[64]}, {31'h0, pslverr});
        end
    end

    // hang guard
    initial begin
        repeat (90000) @(posedge pclk);
        n_errors++;
        report_and_stop();
    end

    // main sequence
    initial begin
        int hi, per;
        logic [1:0] held;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        xfer(0, cpc_pkg::CTRL_OFS, 0, 32'h3ffff, 0, 0);
        xfer(0, cpc_pkg::STAT_OFS, 0, 32'h3, 32'h2, 0);
        xfer(0, 12'h010, 0, 32'hffffffff, 0, 1);
        xfer(1, 12'h014, 32'h5a5a5a5a, 0, 0, 1);
        xfer(1, cpc_pkg::CLK_OFS, 32'h3, 0, 0, 0);
        repeat (20) @(posedge pclk);
        $display("done reset regs");
        for (int i = 0; i < 24; i++) begin
            seed = lfsr(seed);
            voice_tx_bit <= seed[20];
            xfer(1, cpc_pkg::CTRL_OFS, {14'h0, seed[17:0]}, 0, 0, 0);
            repeat (3) @(posedge pclk);
            cmp("power", {17'h0, exp_pwr(seed[17:0])}, {17'h0, pwr});
        end
        xfer(0, cpc_pkg::CTRL_OFS, 0, 32'h3ffff, {14'h0, seed[17:0]}, 0);
        $display("done power");
        for (int i = 0; i < 3; i++) begin
            xfer(1, cpc_pkg::CTRL_OFS, i == 2 ? 32'h141 : 32'h140, 0, 0, 0);
            xfer(1, cpc_pkg::DIV_OFS, (vt[i] << 16) | bbt[i], 0, 0, 0);
            repeat (2) meas(0, hi, per);
            cmp_cnt("bb period", bbt[i] == 0 ? MP : 2 * bbt[i] * MP, per);
            cmp_cnt("bb high", per / 2, hi);
            repeat (2) meas(1, hi, per);
            cmp_cnt("voice period", 5 * (vt[i] + 1) * MP, per);
            cmp_cnt("voice high", 2 * (vt[i] + 1) * MP, hi);
        end
        $display("done clock rates");
        xfer(1, cpc_pkg::CLK_OFS, 32'h2, 0, 0, 0);
        repeat (40) @(posedge pclk);
        held = pclks;
        repeat (40) @(posedge pclk);
        cmp("frozen clocks", {30'h0, held}, {30'h0, pclks});
        cmp("stopped", 0, {25'h0, mclk_running, pwr[14:9]});
        xfer(0, cpc_pkg::STAT_OFS, 0, 32'h3, 32'h2, 0);
        xfer(1, cpc_pkg::CLK_OFS, 32'h3, 0, 0, 0);
        repeat (20) @(posedge pclk);
        xfer(0, cpc_pkg::STAT_OFS, 0, 32'h3, 32'h1, 0);
        $display("done clock stop");
        repeat (2) @(posedge pclk);
        report_and_stop();
    end
endmodule : tb_codec_power_and_port_clock_control
